// ===== tprb_bank.sv
`timescale 1ns/10ps
`include "tprb_map.svh"

module tprb_bank (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire tprb_pkg::tprb_req_t req_i,
    output logic resp_valid_o,
    output tprb_pkg::tprb_resp_t resp_o,
    input wire tprb_pkg::tprb_events_t events_i,
    input wire logic [15:0] err_code_i,
    input wire logic [31:0] weight_i,
    input wire logic [15:0] weight_decimals_i,
    input wire logic [15:0] aout_value_i,
    input wire logic [15:0] bridge_input_i,
    input wire logic level_on_bridge_i,
    input wire logic relay1_i,
    input wire logic relay2_i,
    input wire logic din1_i,
    input wire logic din2_i,
    input wire logic pwr_fail_i,
    input wire logic aout_fixed_mode_i,
    input wire logic aout_voltage_i,
    input wire logic [15:0] saved_level1_i,
    input wire logic [15:0] saved_level2_i,
    input wire logic [15:0] saved_fixed_i,
    input wire logic [15:0] aout_live_i,
    output logic [15:0] aout_drive_o,
    output logic zero_pulse_o,
    output logic [6:0] state_o
);

    //////////////////////////////////////////////////////////////////////////
    // helpers

    // exact for any 16-bit unsigned value, so no rounding is needed
    function automatic logic [31:0] u16_to_float(input logic [15:0] v);
        logic [4:0] p;
        logic [15:0] sh;
        logic [31:0] r;
        p = 5'h00;
        r = 32'h00000000;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                p = i[4:0];
            end
        end
        sh = v << (5'h0F - p);
        if (v != 16'h0000) begin
            r = {1'b0, 8'h7F + {3'h0, p}, sh[14:0], 8'h00};
        end
        return r;
    endfunction

    function automatic logic above(input logic [15:0] val,
                                   input logic [15:0] lvl);
        return $signed(val) > $signed(lvl);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // state

    tprb_pkg::tprb_state_t state_reg, state_next;
    logic [15:0] ierr_reg, ierr_next;
    logic [15:0] cmd_err_reg, cmd_err_next;
    logic [15:0] level1_reg, level1_next;
    logic [15:0] level2_reg, level2_next;
    logic [15:0] fixed_reg, fixed_next;
    logic pwr_fail_reg, pwr_fail_next;
    logic resp_valid_reg, resp_valid_next;
    tprb_pkg::tprb_resp_t resp_reg, resp_next;
    logic zero_reg, zero_next;
    logic [15:0] aout_drive_reg, aout_drive_next;

    logic [15:0] stat1_w, stat2_w, meas_w;
    logic [31:0] weight_abs_w;
    logic start_ok_w;

    //////////////////////////////////////////////////////////////////////////
    // status words

    always_comb begin
        meas_w = level_on_bridge_i ? bridge_input_i : weight_i[15:0];
        weight_abs_w = weight_i[31] ? (32'h00000000 - weight_i) : weight_i;
        stat1_w = 16'h0000; // [R9]
        stat1_w[`TPRB_S1_INT_OVF] =
            (weight_i[31:15] != 17'h00000) &&
            (weight_i[31:15] != 17'h1FFFF); // [R10]
        stat1_w[`TPRB_S1_PREC] = weight_abs_w > `TPRB_SIX_DIGIT_MAX; // [R11]
        stat2_w = 16'h0000; // [R9]
        stat2_w[`TPRB_S2_RELAY1] = relay1_i; // [R13]
        stat2_w[`TPRB_S2_RELAY2] = relay2_i; // [R13]
        stat2_w[`TPRB_S2_PWR_FAIL] = pwr_fail_reg; // [R14]
        stat2_w[`TPRB_S2_FIXED] = aout_fixed_mode_i; // [R15]
        stat2_w[`TPRB_S2_DIN1] = din1_i; // [R13]
        stat2_w[`TPRB_S2_DIN2] = din2_i; // [R13]
        stat2_w[`TPRB_S2_ABOVE1] = above(meas_w, level1_reg); // [R16]
        stat2_w[`TPRB_S2_ABOVE2] = above(meas_w, level2_reg); // [R16]
        stat2_w[`TPRB_S2_VOLT] = aout_voltage_i; // [R15]
    end

    //////////////////////////////////////////////////////////////////////////
    // register access, command handling and instrument state

    always_comb begin
        logic [31:0] f;
        logic is_write;
        logic read_clear;
        f = 32'h00000000;
        read_clear = 1'b0;
        state_next = state_reg;
        ierr_next = (err_code_i > `TPRB_IERR_MAX) ?
            `TPRB_IERR_MAX : err_code_i; // [R8]
        cmd_err_next = cmd_err_reg;
        level1_next = level1_reg;
        level2_next = level2_reg;
        fixed_next = fixed_reg;
        zero_next = 1'b0;
        resp_valid_next = req_valid_i;
        resp_next.exc = `TPRB_EXC_NONE;
        resp_next.rdata = `TPRB_RESET_WORD;
        start_ok_w = state_reg == tprb_pkg::TPRB_ST_WAIT;
        is_write = (req_i.func == `TPRB_FN_WRITE1) ||
                   (req_i.func == `TPRB_FN_WRITEN); // [R24]

        // state moves driven by the instrument itself
        case (state_reg)
            tprb_pkg::TPRB_ST_STARTUP: begin
                level1_next = saved_level1_i; // [R22]
                level2_next = saved_level2_i; // [R22]
                fixed_next = saved_fixed_i; // [R22]
                if (events_i.startup_fatal) begin
                    state_next = tprb_pkg::TPRB_ST_FATAL;
                end else if (events_i.startup_err) begin
                    state_next = tprb_pkg::TPRB_ST_ERROR; // [R7]
                end else if (events_i.startup_done) begin
                    state_next = events_i.need_start ?
                        tprb_pkg::TPRB_ST_WAIT :
                        tprb_pkg::TPRB_ST_NORMAL;
                end
            end
            tprb_pkg::TPRB_ST_WAIT: begin
                state_next = tprb_pkg::TPRB_ST_WAIT; // [R2]
            end
            tprb_pkg::TPRB_ST_NORMAL: begin
                // weight errors do not leave normal
                if (events_i.param_err) begin
                    state_next = tprb_pkg::TPRB_ST_ERROR; // [R3]
                end else if (events_i.local_enter) begin
                    state_next = tprb_pkg::TPRB_ST_LOCAL;
                end else if (events_i.remote_setup_enter) begin
                    state_next = tprb_pkg::TPRB_ST_REMOTE_SETUP;
                end else if (events_i.remote_restore_enter) begin
                    state_next = tprb_pkg::TPRB_ST_REMOTE_RESTORE;
                end else if (events_i.test_enter) begin
                    state_next = tprb_pkg::TPRB_ST_TEST;
                end else if (events_i.boot_enter) begin
                    state_next = tprb_pkg::TPRB_ST_BOOT;
                end
            end
            tprb_pkg::TPRB_ST_LOCAL: begin
                // remote entry requests ignored here
                if (events_i.local_exit) begin
                    state_next = tprb_pkg::TPRB_ST_NORMAL; // [R4]
                end
            end
            tprb_pkg::TPRB_ST_REMOTE_SETUP,
            tprb_pkg::TPRB_ST_REMOTE_RESTORE: begin
                // local entry requests ignored here
                if (events_i.remote_exit) begin
                    state_next = tprb_pkg::TPRB_ST_NORMAL; // [R5]
                end
            end
            tprb_pkg::TPRB_ST_FATAL: begin
                state_next = tprb_pkg::TPRB_ST_FATAL; // [R6]
            end
            tprb_pkg::TPRB_ST_ERROR,
            tprb_pkg::TPRB_ST_TEST,
            tprb_pkg::TPRB_ST_BOOT: begin
                state_next = state_reg;
            end
            default: begin
                state_next = tprb_pkg::TPRB_ST_STARTUP;
            end
        endcase

        if (req_valid_i) begin
            if (req_i.func == `TPRB_FN_READ) begin
                case (req_i.addr)
                    `TPRB_REG_CMD_ERR: resp_next.rdata = cmd_err_reg;
                    `TPRB_REG_STATE:
                        resp_next.rdata = {9'h000, state_reg}; // [R1]
                    `TPRB_REG_IERR: resp_next.rdata = ierr_reg; // [R8]
                    `TPRB_REG_STAT1: resp_next.rdata = stat1_w;
                    `TPRB_REG_STAT2: begin
                        resp_next.rdata = stat2_w;
                        read_clear = 1'b1; // [R14]
                    end
                    `TPRB_REG_WEIGHT: resp_next.rdata = weight_i[31:16];
                    `TPRB_REG_WEIGHT + 16'h0001:
                        resp_next.rdata = weight_i[15:0];
                    `TPRB_REG_WEIGHT + 16'h0002:
                        resp_next.rdata = weight_decimals_i;
                    `TPRB_REG_AOUT: resp_next.rdata = aout_value_i; // [R18]
                    `TPRB_REG_INPUT: resp_next.rdata = bridge_input_i;
                    `TPRB_REG_CMD:
                        resp_next.rdata = `TPRB_RESET_WORD; // [R19]
                    `TPRB_REG_LEVEL1: resp_next.rdata = level1_reg;
                    `TPRB_REG_LEVEL2: resp_next.rdata = level2_reg;
                    `TPRB_REG_FIXED: resp_next.rdata = fixed_reg;
                    `TPRB_REG_F_STAT1: begin
                        f = u16_to_float(stat1_w); // [R12]
                        resp_next.rdata = f[31:16];
                    end
                    `TPRB_REG_F_STAT1 + 16'h0001: begin
                        f = u16_to_float(stat1_w); // [R12]
                        resp_next.rdata = f[15:0];
                    end
                    `TPRB_REG_F_STAT2: begin
                        f = u16_to_float(stat2_w); // [R12]
                        resp_next.rdata = f[31:16];
                        read_clear = 1'b1; // [R14]
                    end
                    `TPRB_REG_F_STAT2 + 16'h0001: begin
                        f = u16_to_float(stat2_w); // [R12]
                        resp_next.rdata = f[15:0];
                    end
                    default: resp_next.exc = `TPRB_EXC_ADDR;
                endcase
            end else if (is_write) begin
                case (req_i.addr)
                    `TPRB_REG_LEVEL1: level1_next = req_i.wdata; // [R22]
                    `TPRB_REG_LEVEL2: level2_next = req_i.wdata; // [R22]
                    `TPRB_REG_FIXED: fixed_next = req_i.wdata; // [R22]
                    `TPRB_REG_CMD: begin
                        // zero command pulses the zero output and clears the command error
                        if (req_i.wdata == `TPRB_CMD_ZERO) begin
                            zero_next = 1'b1; // [R20]
                            cmd_err_next = `TPRB_CERR_NONE;
                        end else if (req_i.wdata == `TPRB_CMD_START) begin
                            if (start_ok_w) begin
                                state_next = tprb_pkg::TPRB_ST_NORMAL; // [R20]
                                cmd_err_next = `TPRB_CERR_NONE;
                            end else begin
                                resp_next.exc = `TPRB_EXC_NAK; // [R21]
                                cmd_err_next = `TPRB_CERR_BAD_STATE; // [R25]
                            end
                        end else if (req_i.wdata != 16'h0000) begin // [R19]
                            resp_next.exc = `TPRB_EXC_VALUE; // [R21]
                            cmd_err_next = `TPRB_CERR_BAD_CMD; // [R25]
                        end
                    end
                    default: resp_next.exc = `TPRB_EXC_ADDR;
                endcase
            end else begin
                resp_next.exc = `TPRB_EXC_FUNC;
            end
        end

        // a new failure in the clearing cycle survives
        pwr_fail_next = pwr_fail_i | (pwr_fail_reg & ~read_clear); // [R14]

        aout_drive_next = aout_fixed_mode_i ? fixed_reg : aout_live_i; // [R23]
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= tprb_pkg::TPRB_ST_STARTUP; // [R1]
            ierr_reg <= `TPRB_RESET_WORD;
            cmd_err_reg <= `TPRB_CERR_NONE;
            level1_reg <= `TPRB_RESET_WORD;
            level2_reg <= `TPRB_RESET_WORD;
            fixed_reg <= `TPRB_RESET_WORD;
            pwr_fail_reg <= 1'b0;
            resp_valid_reg <= 1'b0;
            resp_reg <= '0;
            zero_reg <= 1'b0;
            aout_drive_reg <= `TPRB_RESET_WORD;
        end else begin
            state_reg <= state_next;
            ierr_reg <= ierr_next;
            cmd_err_reg <= cmd_err_next;
            level1_reg <= level1_next;
            level2_reg <= level2_next;
            fixed_reg <= fixed_next;
            pwr_fail_reg <= pwr_fail_next;
            resp_valid_reg <= resp_valid_next;
            resp_reg <= resp_next;
            zero_reg <= zero_next;
            aout_drive_reg <= aout_drive_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs

    assign resp_valid_o = resp_valid_reg;
    assign resp_o = resp_reg;
    assign zero_pulse_o = zero_reg;
    assign state_o = state_reg;
    assign aout_drive_o = aout_drive_reg;

endmodule

// ===== tprb_bank_properties.sv
`timescale 1ns/10ps
`include "tprb_map.svh"

module tprb_bank_properties (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire tprb_pkg::tprb_req_t req_i,
    input wire logic resp_valid_o,
    input wire tprb_pkg::tprb_resp_t resp_o,
    input wire logic zero_pulse_o,
    input wire logic [6:0] state_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    logic rd_req;
    logic cmd_wr;
    assign rd_req = req_valid_i && req_i.func == `TPRB_FN_READ;
    assign cmd_wr = req_valid_i && req_i.func == `TPRB_FN_WRITE1
        && req_i.addr == `TPRB_REG_CMD;

    ////////////////////////////////////////////////////////////////////////
    sequence s_zero_pulse;
        zero_pulse_o ##1 !zero_pulse_o;
    endsequence

    a_resp_timing: assert property (
        resp_valid_o == $past(req_valid_i))
        else $error("answer strobe not one cycle after request");
    a_bad_func: assert property (req_valid_i && !(req_i.func inside
        {`TPRB_FN_READ, `TPRB_FN_WRITE1, `TPRB_FN_WRITEN})
        |=> resp_o.exc == `TPRB_EXC_FUNC) else $error("bad function kept");
    a_cmd_reads_zero: assert property (rd_req &&
        req_i.addr == `TPRB_REG_CMD |=> resp_o.rdata == 16'h0000)
        else $error("command register read not zero");
    a_ierr_range: assert property (rd_req &&
        req_i.addr == `TPRB_REG_IERR |=> resp_o.rdata <= `TPRB_IERR_MAX)
        else $error("error code out of range");
    a_stat1_unused: assert property (rd_req &&
        req_i.addr == `TPRB_REG_STAT1 |=> (resp_o.rdata & 16'hDFFD) == 0)
        else $error("unassigned status bit set");
    a_start_refused: assert property (cmd_wr &&
        req_i.wdata == `TPRB_CMD_START && state_o != 7'h01
        |=> resp_o.exc == `TPRB_EXC_NAK && $stable(state_o))
        else $error("start outside wait not refused");
    a_zero_pulse: assert property (cmd_wr &&
        req_i.wdata == `TPRB_CMD_ZERO |=> s_zero_pulse)
        else $error("zero pulse missing");
    a_fatal_hold: assert property (state_o == 7'h07
        |=> state_o == 7'h07) else $error("left fatal state");
    a_local_block: assert property (state_o == 7'h03
        |=> !(state_o inside {7'h04, 7'h05})) else $error("local to remote");
    a_remote_block: assert property (state_o inside {7'h04, 7'h05}
        |=> state_o != 7'h03) else $error("remote to local");
endmodule

bind tprb_bank tprb_bank_properties tprb_bank_properties_i (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .zero_pulse_o(zero_pulse_o), .state_o(state_o));

// ===== tprb_bank_tb.sv
`timescale 1ns/10ps
`include "tprb_map.svh"

module tprb_bank_tb;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid;
    tprb_pkg::tprb_req_t req;
    logic resp_valid;
    tprb_pkg::tprb_resp_t resp;
    tprb_pkg::tprb_events_t ev = '0;
    logic pwr = 1'b0;
    logic fixed_mode = 1'b1;
    logic [15:0] ecode = 16'h00C8, bridge = 16'h0456, live = 16'h0777;
    logic [31:0] weight = 32'h000F4240;
    logic lvl_src = 1'b0, rly1 = 1'b1, rly2 = 1'b0;
    logic di1 = 1'b0, di2 = 1'b1, volt = 1'b1;
    logic zp;
    logic [15:0] drive;
    logic [6:0] state;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] e;
    logic [15:0] d;
    logic [7:0] f, xe;
    logic [15:0] a, w, xd;
    // func, addr, wdata, exception, read data
    logic [63:0] rows [19] = '{
        {8'h06, 16'h001F, 16'h0100, 8'h00, 16'h0000},
        {8'h03, 16'h000B, 16'h0000, 8'h00, 16'h0B51},
        {8'h03, 16'h000B, 16'h0000, 8'h00, 16'h0B41},
        {8'h03, 16'h00DA, 16'h0000, 8'h00, 16'h4534},
        {8'h03, 16'h0008, 16'h0000, 8'h00, 16'h0002},
        {8'h03, 16'h0009, 16'h0000, 8'h00, 16'h0063},
        {8'h03, 16'h000A, 16'h0000, 8'h00, 16'h2002},
        {8'h03, 16'h00D8, 16'h0000, 8'h00, 16'h4600},
        {8'h03, 16'h00D9, 16'h0000, 8'h00, 16'h0800},
        {8'h03, 16'h000C, 16'h0000, 8'h00, 16'h000F},
        {8'h03, 16'h000D, 16'h0000, 8'h00, 16'h4240},
        {8'h03, 16'h0018, 16'h0000, 8'h00, 16'h0123},
        {8'h03, 16'h001B, 16'h0000, 8'h00, 16'h0456},
        {8'h06, 16'h001E, 16'h0005, 8'h03, 16'h0000},
        {8'h06, 16'h001E, 16'h0000, 8'h00, 16'h0000},
        {8'h03, 16'h0007, 16'h0000, 8'h00, 16'h0064},
        {8'h10, 16'h0025, 16'h1234, 8'h00, 16'h0000},
        {8'h03, 16'h0025, 16'h0000, 8'h00, 16'h1234},
        {8'h05, 16'h0008, 16'h0000, 8'h01, 16'h0000}};

    tprb_bank tprb_bank_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .req_valid_i(req_valid), .req_i(req), .resp_valid_o(resp_valid),
        .resp_o(resp), .events_i(ev), .err_code_i(ecode),
        .weight_i(weight), .weight_decimals_i(16'h0003),
        .aout_value_i(16'h0123), .bridge_input_i(bridge),
        .level_on_bridge_i(lvl_src), .relay1_i(rly1), .relay2_i(rly2),
        .din1_i(di1), .din2_i(di2), .pwr_fail_i(pwr),
        .aout_fixed_mode_i(fixed_mode), .aout_voltage_i(volt),
        .saved_level1_i(16'h0055), .saved_level2_i(16'h7000),
        .saved_fixed_i(16'h0011), .aout_live_i(live),
        .aout_drive_o(drive), .zero_pulse_o(zp), .state_o(state));
    tprb_master tprb_master_i (.core_clk_i(core_clk_i),
        .req_valid_o(req_valid), .req_o(req), .resp_valid_i(resp_valid),
        .resp_i(resp));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ceiling well above the hundred or so cycles the run needs
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done;
        end
    end

    task automatic chk(input string n, input logic [15:0] x,
        input logic [15:0] g);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic do_reset(input tprb_pkg::tprb_events_t v);
        nrst_i = 1'b0;
        ev = v;
        repeat (5) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
    endtask

    task automatic set_ev(input tprb_pkg::tprb_events_t v);
        ev = v;
        repeat (2) @(negedge core_clk_i);
    endtask

    task test_done;
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset('0);
        chk("state start", 16'h0000, {9'h000, state});
        tprb_master_i.xfer(8'h03, 16'h001F, 16'h0000, e, d);
        chk("level1 saved", 16'h0055, d);
        tprb_master_i.xfer(8'h06, 16'h001E, 16'h0010, e, d);
        chk("start refused", 16'h0007, {8'h00, e});
        tprb_master_i.xfer(8'h03, 16'h0007, 16'h0000, e, d);
        chk("cmd error", 16'h0065, d);
        chk("state kept", 16'h0000, {9'h000, state});
        set_ev(12'h900);
        chk("state wait", 16'h0001, {9'h000, state});
        set_ev('0);
        chk("state held", 16'h0001, {9'h000, state});
        tprb_master_i.xfer(8'h06, 16'h001E, 16'h0010, e, d);
        chk("start ok", 16'h0000, {8'h00, e});
        chk("state normal", 16'h0002, {9'h000, state});
        tprb_master_i.xfer(8'h06, 16'h001E, 16'h0008, e, d);
        chk("zero pulse", 16'h0001, {15'h0000, zp});
        tprb_master_i.xfer(8'h03, 16'h0007, 16'h0000, e, d);
        chk("cmd error clear", 16'h0000, d);
        chk("zero end", 16'h0000, {15'h0000, zp});
        tprb_master_i.xfer(8'h06, 16'h0008, 16'h0001, e, d);
        chk("write ro", 16'h0002, {8'h00, e});
        tprb_master_i.xfer(8'h03, 16'h0100, 16'h0000, e, d);
        chk("unmapped", 16'h0002, {8'h00, e});
        pwr = 1'b1;
        @(negedge core_clk_i);
        pwr = 1'b0;
        foreach (rows[i]) begin
            {f, a, w, xe, xd} = rows[i];
            tprb_master_i.xfer(f, a, w, e, d);
            chk("row exc", {8'h00, xe}, {8'h00, e});
            if (f == `TPRB_FN_READ && xe == 8'h00) begin
                chk("row data", xd, d);
            end
        end
        chk("fixed drive", 16'h1234, drive);
        fixed_mode = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk("live drive", 16'h0777, drive);
        // flip every status source so each bit but bit 9, above level one, is seen in both levels
        rly1 = 1'b0;
        rly2 = 1'b1;
        di1 = 1'b1;
        di2 = 1'b0;
        volt = 1'b0;
        lvl_src = 1'b1;
        bridge = 16'h7100;
        weight = 32'hFFFFFF9C;
        ecode = 16'h0000;
        tprb_master_i.xfer(8'h03, 16'h000B, 16'h0000, e, d);
        chk("status two", 16'h0682, d);
        tprb_master_i.xfer(8'h03, 16'h000A, 16'h0000, e, d);
        chk("status one", 16'h0000, d);
        tprb_master_i.xfer(8'h03, 16'h00D8, 16'h0000, e, d);
        chk("float zero", 16'h0000, d);
        tprb_master_i.xfer(8'h03, 16'h0009, 16'h0000, e, d);
        chk("no error", 16'h0000, d);
        chk("wt ok", 16'h0001, {15'h0000, tprb_master_i.weight_ok});
        set_ev(12'h040);
        set_ev(12'h010);
        chk("local kept", 16'h0003, {9'h000, state});
        set_ev(12'h020);
        set_ev(12'h010);
        chk("remote", 16'h0004, {9'h000, state});
        set_ev(12'h040);
        chk("remote kept", 16'h0004, {9'h000, state});
        do_reset(12'h400);
        chk("state error", 16'h0006, {9'h000, state});
        tprb_master_i.xfer(8'h03, 16'h001F, 16'h0000, e, d);
        chk("level1 reload", 16'h0055, d);
        do_reset(12'h200);
        set_ev(12'h900);
        chk("state fatal", 16'h0007, {9'h000, state});
        test_done;
    end
endmodule

// ===== tprb_map.svh
//////////////////////////////////////////////////////////////////////////////
// Function
// [R1] state 00 start 01 wait 02 normal 06 error 07 fatal 08 test 99 boot
// [R2] wait-for-start state holds until a start command arrives
// [R3] normal state shown whenever no parameter error, weight errors ignored
// [R4] local set-up state refuses entry to remote set-up or restore
// [R5] remote set-up or restore states refuse entry to local set-up
// [R6] fatal error state is terminal, no exit except reset
// [R7] error found during start-up enters error state 06
// [R8] instrument error register holds code 000..099, zero meaning no error
// [R9] status bit 0 is lsb, one is true, unassigned bits read zero
// [R10] status one bit 1 set when weight does not fit 16 bits
// [R11] status one bit 13 set when weight exceeds six digits
// [R12] status read in float area returns bit value encoded as float
// [R13] status two bits 0,1 relays; bits 7,8 digital inputs
// [R14] status two bit 4 power failure, cleared after function 03 read
// [R15] status two bit 6 fixed analogue mode, bit 11 voltage output
// [R16] status two bits 9,10 set while value above level one, two
// [R17] master trusts weight only when error register reads 00
// [R18] analogue output readback shows output rounded to two decimals
// [R19] command register reads zero; only non-zero write acts
// [R20] command 8 zeroes, command 16 starts only in wait state
// [R21] refused command gives exception; codes 03,07 store command error
// [R22] levels and fixed value writable, reloaded from set-up at start-up
// [R23] fixed value drives analogue output only in fixed mode
// [R24] registers 16 bits, read function 03, written by 06 or 16
// [R25] rejected command changes nothing but the command error register
//////////////////////////////////////////////////////////////////////////////
`ifndef TPRB_MAP_SVH
`define TPRB_MAP_SVH

// register numbers, offset from 40000
`define TPRB_REG_CMD_ERR 16'h0007
`define TPRB_REG_STATE 16'h0008
`define TPRB_REG_IERR 16'h0009
`define TPRB_REG_STAT1 16'h000A
`define TPRB_REG_STAT2 16'h000B
`define TPRB_REG_WEIGHT 16'h000C
`define TPRB_REG_AOUT 16'h0018
`define TPRB_REG_INPUT 16'h001B
`define TPRB_REG_CMD 16'h001E
`define TPRB_REG_LEVEL1 16'h001F
`define TPRB_REG_LEVEL2 16'h0022
`define TPRB_REG_FIXED 16'h0025
`define TPRB_REG_F_STAT1 16'h00D8
`define TPRB_REG_F_STAT2 16'h00DA

// bus functions
`define TPRB_FN_READ 8'h03
`define TPRB_FN_WRITE1 8'h06
`define TPRB_FN_WRITEN 8'h10

// exception codes
`define TPRB_EXC_NONE 8'h00
`define TPRB_EXC_FUNC 8'h01
`define TPRB_EXC_ADDR 8'h02
`define TPRB_EXC_VALUE 8'h03
`define TPRB_EXC_NAK 8'h07

// commands and command error codes
`define TPRB_CMD_ZERO 16'h0008
`define TPRB_CMD_START 16'h0010
`define TPRB_CERR_NONE 16'h0000
`define TPRB_CERR_BAD_CMD 16'h0064
`define TPRB_CERR_BAD_STATE 16'h0065

// status bit positions
`define TPRB_S1_INT_OVF 1
`define TPRB_S1_PREC 13
`define TPRB_S2_RELAY1 0
`define TPRB_S2_RELAY2 1
`define TPRB_S2_PWR_FAIL 4
`define TPRB_S2_FIXED 6
`define TPRB_S2_DIN1 7
`define TPRB_S2_DIN2 8
`define TPRB_S2_ABOVE1 9
`define TPRB_S2_ABOVE2 10
`define TPRB_S2_VOLT 11

// limits and reset values
`define TPRB_IERR_MAX 16'h0063
`define TPRB_SIX_DIGIT_MAX 32'h000F423F
`define TPRB_RESET_WORD 16'h0000

`endif

// ===== tprb_master.sv
`timescale 1ns/10ps
`include "tprb_map.svh"

module tprb_master (
    input wire logic core_clk_i,
    output logic req_valid_o,
    output tprb_pkg::tprb_req_t req_o,
    input wire logic resp_valid_i,
    input wire tprb_pkg::tprb_resp_t resp_i
);
    logic weight_ok = 1'b0;
    initial req_valid_o = 1'b0;
    initial req_o = '0;

    // one word per call; idle cycle after, bus shows inverse when released
    task automatic xfer(input logic [7:0] f, input logic [15:0] a,
        input logic [15:0] w, output logic [7:0] e, output logic [15:0] d);
        @(negedge core_clk_i);
        req_o = '{func: f, addr: a, wdata: w};
        req_valid_o = 1'b1;
        @(negedge core_clk_i);
        e = resp_valid_i ? resp_i.exc : 8'hFF;
        d = resp_i.rdata;
        if (f == `TPRB_FN_READ && a == `TPRB_REG_IERR) begin
            weight_ok = (d == 16'h0000);
        end
        req_valid_o = 1'b0;
        req_o = ~req_o;
    endtask
endmodule

// ===== tprb_pkg.sv
package tprb_pkg;

    typedef enum logic [6:0] {
        TPRB_ST_STARTUP = 7'h00,
        TPRB_ST_WAIT = 7'h01,
        TPRB_ST_NORMAL = 7'h02,
        TPRB_ST_LOCAL = 7'h03,
        TPRB_ST_REMOTE_SETUP = 7'h04,
        TPRB_ST_REMOTE_RESTORE = 7'h05,
        TPRB_ST_ERROR = 7'h06,
        TPRB_ST_FATAL = 7'h07,
        TPRB_ST_TEST = 7'h08,
        TPRB_ST_BOOT = 7'h63
    } tprb_state_t;

    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } tprb_req_t;

    typedef struct packed {
        logic [7:0] exc;
        logic [15:0] rdata;
    } tprb_resp_t;

    typedef struct packed {
        logic startup_done;
        logic startup_err;
        logic startup_fatal;
        logic need_start;
        logic param_err;
        logic local_enter;
        logic local_exit;
        logic remote_setup_enter;
        logic remote_restore_enter;
        logic remote_exit;
        logic test_enter;
        logic boot_enter;
    } tprb_events_t;

endpackage
